// ---- sfr_pkg.sv ----
/*
  sfr_pkg: shared constants and types of the serial flash read engine.
  Assumes nothing of its surroundings; imported by every design file except sfr_sync.
*/
package sfr_pkg;

  // instruction codes taken on lane zero
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;

  // bit counts of the header phases, turned into clocks by the lane width; dummy counts are in clocks
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WRAP_DUMMY_BITS = 5'h18;
  localparam logic [4:0] FAST_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] QUAD_IO_DUMMY_CLKS = 5'h04;
  localparam logic [4:0] NO_DUMMY_CLKS = 5'h00;

  // lane width codes, equal to log2 of the lanes in use
  localparam logic [1:0] LN_X1 = 2'h0;
  localparam logic [1:0] LN_X2 = 2'h1;
  localparam logic [1:0] LN_X4 = 2'h2;

  // continuous_mode_select value that keeps the opcode-less mode
  localparam logic [1:0] MODE_KEEP = 2'h2;

  // wrap_setting = {wrap_length_field, wrap_disable_bit}; wrapping off
  localparam logic [2:0] WRAP_SETTING_RST = 3'h1;
  localparam logic [23:0] WRAP_MIN_SPAN = 24'h000008;

  // address width of the array: 4 Mbit = 512 KiB
  localparam int ARRAY_ADDR_W = 19;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
    ST_WRAP_DUMMY, ST_WRAP_BYTE, ST_IGNORE
  } sfr_state_t;

  typedef enum logic [1:0] {CM_NONE, CM_DUAL, CM_QUAD} sfr_cont_t;

  // the four data lanes, lane three in the top bit
  typedef struct packed {
    logic three;
    logic two;
    logic one;
    logic zero;
  } sfr_lanes_t;

  // array preload write from the system side
  typedef struct packed {
    logic en;
    logic [23:0] addr;
    logic [7:0] data;
  } sfr_load_t;

endpackage

// ---- sfr_sync.sv ----
/*
  sfr_sync: two-flop level synchroniser, W bits wide.
  Assumes each bit is a slow level; no word coherence across bits.
*/
`timescale 1ns/1ps
module sfr_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk_in,
  input wire logic reset_in,
  // level to carry over and its synchronised copy
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  if (W < 1) begin : g_bad_width
    $error("sfr_sync: W must be at least 1");
  end

  // first stage is read by the second stage only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule // sfr_sync

// ---- sfr_mem.sv ----
/*
  sfr_mem: byte array of the flash, written from the system clock and
  read on the link clock with a registered read port.
  Assumes writes and reads of one byte do not overlap in time.
*/
`timescale 1ns/1ps
module sfr_mem
  import sfr_pkg::*;
#(
  parameter int ADDR_W = ARRAY_ADDR_W
) (
  // preload port, system clock
  input wire logic wr_clk_in,
  input wire sfr_load_t wr_in,
  // read port, link clock
  input wire logic rd_clk_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem_r [0:(1<<ADDR_W)-1];

  if (ADDR_W < 8 || ADDR_W > 24) begin : g_bad_addr
    $error("sfr_mem: ADDR_W must lie in 8..24");
  end

  // preload, no reset: contents stand for the nonvolatile array
  always_ff @(posedge wr_clk_in) begin
    if (wr_in.en) begin
      mem_r[wr_in.addr[ADDR_W-1:0]] <= wr_in.data;
    end
  end

  // registered read, one link clock of latency
  always_ff @(posedge rd_clk_in) begin
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule // sfr_mem

// ---- sfr_read_engine.sv ----
/*
  sfr_read_engine: read instruction logic of a serial NOR flash on its
  one/two/four lane serial link, with opcode-less continuous reads and
  burst wrap. Inputs are sampled on rising link clock edges, outputs
  change on falling edges.
  Assumes an external host makes the link clock only while chip select
  is low; busy and quad enable come as levels from the system clock.
*/
// Functional notes
// - standard read takes opcode and 24-bit address on lane zero, rising edges
// - addressed byte goes out on lane one, MSB first, falling edges
// - address steps by one after each byte; streaming continues with clocks
// - chip select high ends the instruction and releases the outputs
// - reads arriving while busy are ignored and leave the busy cycle alone; opcode-less frames check busy as synchronised during the previous frame
// - fast read inserts eight dummy clocks; output then undefined
// - dual output read: one-lane header, eight dummies, two bits a clock
// - quad output read: eight dummies, four lanes, only with quad enable
// - dual I/O read: address and mode byte on two lanes, then data
// - low nibble of the mode byte is ignored
// - mode bits 5:4 = 10 make next dual frame opcode-less
// - any other mode bits 5:4 restore normal opcode decoding
// - quad I/O read: four-lane address and mode, four dummies, quad enable
// - quad I/O mode bits 5:4 = 10 make next frame opcode-less
// - a mode reset sequence clears the continuous mode
// - enabled wrap keeps quad I/O reads inside an aligned 8..64 byte span
// - three-bit wrap setting loaded by the set-wrap instruction
// - set-wrap carries opcode, 24 dummy bits, then the wrap byte
// - wrap disable bit 0 wraps, 1 default; length 00..11 is 8..64
// - all-ones for 8 quad or 16 dual clocks sets mode bit 4
`timescale 1ns/1ps
module sfr_read_engine
  import sfr_pkg::*;
#(
  parameter int ADDR_W = ARRAY_ADDR_W
) (
  // system clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // serial link from the host
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire sfr_lanes_t io_lanes_in,
  output sfr_lanes_t io_lanes_out,
  output sfr_lanes_t io_lanes_oe_out,
  // status of the rest of the device
  input wire logic busy_in,
  input wire logic quad_enable_bit_in,
  // array preload
  input wire sfr_load_t load_in,
  // status towards the system clock
  output logic frame_active_out,
  output logic continuous_mode_out
);
  // array top, used for the roll-over of plain sequential reads
  localparam logic [23:0] ADDR_TOP = 24'((25'h1 << ADDR_W) - 25'h1);

  if (ADDR_W < 8 || ADDR_W > 24) begin : g_bad_addr
    $error("sfr_read_engine: ADDR_W must lie in 8..24");
  end

  // link reset: chip select high clears the frame logic at once
  logic link_rst;

  // frame state, link clock, rising edge
  sfr_state_t state_r;
  sfr_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [1:0] lanes_r;
  logic [1:0] lanes_nxt;
  logic [1:0] dlanes_r;
  logic [1:0] dlanes_nxt;
  logic [4:0] dum_r;
  logic [4:0] dum_nxt;
  logic has_mode_r;
  logic has_mode_nxt;
  logic quad_io_r;
  logic quad_io_nxt;
  logic [23:0] in_sh_r;
  logic [23:0] in_sh_nxt;
  logic [23:0] addr_r;
  logic [23:0] addr_nxt;

  // state that outlives a frame
  sfr_cont_t cont_r;
  sfr_cont_t cont_nxt;
  logic [2:0] wrap_setting_r;
  logic [2:0] wrap_setting_nxt;

  // output side, link clock, falling edge
  logic [7:0] out_sh_r;
  logic [7:0] out_sh_nxt;
  logic [7:0] cur_byte;
  sfr_lanes_t drv_nxt;
  sfr_lanes_t oe_nxt;

  // helpers
  logic [1:0] ln_use;
  logic need_quad;
  logic wrap_on;
  logic busy_s;
  logic qe_s;
  logic [7:0] mem_q;

  // clocks a phase of the given bit count takes on the given lanes
  function automatic logic [4:0] phase_clks(input logic [4:0] bits,
                                            input logic [1:0] ln);
    phase_clks = bits >> ln;
  endfunction

  // shift the lanes sampled on one edge into the low end
  function automatic logic [23:0] shift_in(input logic [23:0] v,
                                           input logic [1:0] ln,
                                           input sfr_lanes_t d);
    unique case (ln)
      LN_X1: shift_in = {v[22:0], d.zero};
      LN_X2: shift_in = {v[21:0], d.one, d.zero};
      default: shift_in = {v[19:0], d};
    endcase
  endfunction

  // following byte address: wrapped inside the span or rolled at the top
  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic wrap_en,
                                            input logic [1:0] len);
    logic [23:0] span;
    logic [23:0] inc;
    span = (WRAP_MIN_SPAN << len) - 24'h000001;
    inc = a + 24'h000001;
    if (wrap_en) begin
      next_addr = (a & ~span) | (inc & span);
    end else begin
      next_addr = inc & ADDR_TOP;
    end
  endfunction

  assign link_rst = reset_in | cs_n_in;

  // busy and quad enable enter the link domain; in opcode frames they settle
  // during the seven opcode edges before they are first looked at
  sfr_sync #(
    .W(2)
  ) u_sync_link (
    .clk_in(sclk_in),
    .reset_in(reset_in),
    .d_in({busy_in, quad_enable_bit_in}),
    .q_out({busy_s, qe_s})
  );

  // frame and continuous mode levels back to the system clock
  sfr_sync #(
    .W(2)
  ) u_sync_sys (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .d_in({~cs_n_in, cont_r != CM_NONE}),
    .q_out({frame_active_out, continuous_mode_out})
  );

  // array; the read address is the next byte address, so the byte is
  // ready before the falling edge that starts sending it
  sfr_mem #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .wr_clk_in(clk_in),
    .wr_in(load_in),
    .rd_clk_in(sclk_in),
    .rd_addr_in(addr_nxt[ADDR_W-1:0]),
    .rd_data_out(mem_q)
  );

  // an opcode-less frame takes its first edge with the stored lanes
  assign ln_use = (state_r == ST_CMD && cont_r != CM_NONE) ?
                  ((cont_r == CM_QUAD) ? LN_X4 : LN_X2) : lanes_r;
  assign in_sh_nxt = shift_in(in_sh_r, ln_use, io_lanes_in);
  assign wrap_on = quad_io_r & ~wrap_setting_r[0];

  // instruction sequencing on rising edges
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 5'h01;
    lanes_nxt = lanes_r;
    dlanes_nxt = dlanes_r;
    dum_nxt = dum_r;
    has_mode_nxt = has_mode_r;
    quad_io_nxt = quad_io_r;
    addr_nxt = addr_r;
    cont_nxt = cont_r;
    wrap_setting_nxt = wrap_setting_r;
    need_quad = 1'b0;
    unique case (state_r)
      ST_CMD: begin
        if (cont_r != CM_NONE) begin
          // first edge is already an address edge
          lanes_nxt = ln_use;
          dlanes_nxt = ln_use;
          has_mode_nxt = 1'b1;
          quad_io_nxt = (cont_r == CM_QUAD);
          dum_nxt = (cont_r == CM_QUAD) ? QUAD_IO_DUMMY_CLKS : NO_DUMMY_CLKS;
          state_nxt = busy_s ? ST_IGNORE : ST_ADDR;
        end else if (cnt_r == BYTE_BITS - 5'h01) begin
          cnt_nxt = 5'h00;
          state_nxt = ST_ADDR;
          lanes_nxt = LN_X1;
          dlanes_nxt = LN_X1;
          dum_nxt = NO_DUMMY_CLKS;
          has_mode_nxt = 1'b0;
          quad_io_nxt = 1'b0;
          case (in_sh_nxt[7:0])
            OP_READ: begin
              dum_nxt = NO_DUMMY_CLKS;
            end
            OP_FAST: begin
              dum_nxt = FAST_DUMMY_CLKS;
            end
            OP_DUAL_OUT: begin
              dum_nxt = FAST_DUMMY_CLKS;
              dlanes_nxt = LN_X2;
            end
            OP_QUAD_OUT: begin
              dum_nxt = FAST_DUMMY_CLKS;
              dlanes_nxt = LN_X4;
              need_quad = 1'b1;
            end
            OP_DUAL_IO: begin
              lanes_nxt = LN_X2;
              dlanes_nxt = LN_X2;
              has_mode_nxt = 1'b1;
            end
            OP_QUAD_IO: begin
              lanes_nxt = LN_X4;
              dlanes_nxt = LN_X4;
              has_mode_nxt = 1'b1;
              quad_io_nxt = 1'b1;
              dum_nxt = QUAD_IO_DUMMY_CLKS;
              need_quad = 1'b1;
            end
            OP_SET_WRAP: begin
              lanes_nxt = LN_X4;
              state_nxt = ST_WRAP_DUMMY;
            end
            // includes the all-ones mode reset byte, which needs no action
            default: begin
              state_nxt = ST_IGNORE;
            end
          endcase
          // refused instructions idle until chip select rises
          if (busy_s || (need_quad && !qe_s)) begin
            state_nxt = ST_IGNORE;
          end
        end
      end
      ST_ADDR: begin
        if (cnt_r == phase_clks(ADDR_BITS, lanes_r) - 5'h01) begin
          cnt_nxt = 5'h00;
          addr_nxt = in_sh_nxt & ADDR_TOP;
          if (has_mode_r) begin
            state_nxt = ST_MODE;
          end else if (dum_r != NO_DUMMY_CLKS) begin
            state_nxt = ST_DUMMY;
          end else begin
            state_nxt = ST_DATA;
          end
        end
      end
      ST_MODE: begin
        if (cnt_r == phase_clks(BYTE_BITS, lanes_r) - 5'h01) begin
          cnt_nxt = 5'h00;
          // only bits 5:4 matter; the low nibble is dropped
          if (in_sh_nxt[5:4] == MODE_KEEP) begin
            cont_nxt = quad_io_r ? CM_QUAD : CM_DUAL;
          end else begin
            cont_nxt = CM_NONE;
          end
          state_nxt = (dum_r != NO_DUMMY_CLKS) ? ST_DUMMY : ST_DATA;
        end
      end
      ST_DUMMY: begin
        if (cnt_r == dum_r - 5'h01) begin
          cnt_nxt = 5'h00;
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (cnt_r == phase_clks(BYTE_BITS, dlanes_r) - 5'h01) begin
          cnt_nxt = 5'h00;
          addr_nxt = next_addr(addr_r, wrap_on, wrap_setting_r[2:1]);
        end
      end
      ST_WRAP_DUMMY: begin
        if (cnt_r == phase_clks(WRAP_DUMMY_BITS, lanes_r) - 5'h01) begin
          cnt_nxt = 5'h00;
          state_nxt = ST_WRAP_BYTE;
        end
      end
      ST_WRAP_BYTE: begin
        if (cnt_r == phase_clks(BYTE_BITS, lanes_r) - 5'h01) begin
          cnt_nxt = 5'h00;
          wrap_setting_nxt = in_sh_nxt[6:4];
          state_nxt = ST_IGNORE;
        end
      end
      ST_IGNORE: begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  // frame registers, cleared whenever chip select is high
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      state_r <= ST_CMD;
      cnt_r <= 5'h00;
      lanes_r <= LN_X1;
      dlanes_r <= LN_X1;
      dum_r <= NO_DUMMY_CLKS;
      has_mode_r <= 1'b0;
      quad_io_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      lanes_r <= lanes_nxt;
      dlanes_r <= dlanes_nxt;
      dum_r <= dum_nxt;
      has_mode_r <= has_mode_nxt;
      quad_io_r <= quad_io_nxt;
    end
  end

  // input shifter and byte address
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      in_sh_r <= 24'h000000;
      addr_r <= 24'h000000;
    end else begin
      in_sh_r <= in_sh_nxt;
      addr_r <= addr_nxt;
    end
  end

  // continuous mode and wrap survive chip select; reset restores their defaults,
  // since the host reaches them otherwise only through mode bytes and set-wrap
  always_ff @(posedge sclk_in or posedge reset_in) begin
    if (reset_in) begin
      cont_r <= CM_NONE;
      wrap_setting_r <= WRAP_SETTING_RST;
    end else begin
      cont_r <= cont_nxt;
      wrap_setting_r <= wrap_setting_nxt;
    end
  end

  // a byte is loaded from the array on its first clock, then shifted
  always_comb begin
    cur_byte = (cnt_r == 5'h00) ? mem_q : out_sh_r;
    unique case (dlanes_r)
      LN_X1: begin
        drv_nxt = {2'b00, cur_byte[7], 1'b0};
        oe_nxt = 4'h2;
        out_sh_nxt = {cur_byte[6:0], 1'b0};
      end
      LN_X2: begin
        drv_nxt = {2'b00, cur_byte[7:6]};
        oe_nxt = 4'h3;
        out_sh_nxt = {cur_byte[5:0], 2'b00};
      end
      default: begin
        drv_nxt = cur_byte[7:4];
        oe_nxt = 4'hF;
        out_sh_nxt = {cur_byte[3:0], 4'h0};
      end
    endcase
  end

  // lanes change on falling edges and are driven in data phase only;
  // the host must have let go of its lanes by then
  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      out_sh_r <= 8'h00;
      io_lanes_out <= 4'h0;
      io_lanes_oe_out <= 4'h0;
    end else if (state_r == ST_DATA) begin
      out_sh_r <= out_sh_nxt;
      io_lanes_out <= drv_nxt;
      io_lanes_oe_out <= oe_nxt;
    end else begin
      io_lanes_out <= 4'h0;
      io_lanes_oe_out <= 4'h0;
    end
  end
endmodule // sfr_read_engine

// ---- sfr_host_model.sv ----
/*
  sfr_host_model: behavioural serial host that clocks frames into the read engine.
  Assumes the bench resolves the pin levels from both parties' enables.
*/
`timescale 1ns/1ps
module sfr_host_model
  import sfr_pkg::*;
(
  // link towards the device
  output logic sclk_out,
  output logic cs_n_out,
  output sfr_lanes_t lanes_out,
  output sfr_lanes_t lanes_oe_out,
  // resolved pins and device drive enables
  input wire sfr_lanes_t pins_in,
  input wire sfr_lanes_t dev_oe_in
);
  logic hdr_drive_r;

  // link idle: clock stands still outside frames
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    lanes_out = '0;
    lanes_oe_out = '0;
    hdr_drive_r = 1'b0;
  end

  task automatic open_frame();
    #40 cs_n_out = 1'b0;
    #40;
  endtask

  // header bits, msb first, one clock per lane group
  task automatic send(input logic [31:0] v, input int nb, input logic [1:0] ln);
    int w;
    w = 1 << ln;
    for (int i = nb - w; i >= 0; i -= w) begin
      lanes_out = sfr_lanes_t'(4'((v >> i) & ((32'h1 << w) - 1)));
      lanes_oe_out = sfr_lanes_t'(4'((32'h1 << w) - 1));
      #32 if (dev_oe_in !== 4'h0) hdr_drive_r = 1'b1;
      sclk_out = 1'b1;
      #16 lanes_oe_out = '0;
      #16 sclk_out = 1'b0;
    end
  endtask

  // data sampled just before each rising edge
  task automatic recv(input logic [1:0] ln, output logic [7:0] b, output sfr_lanes_t oe);
    int w;
    w = 1 << ln;
    b = 8'h00;
    oe = '0;
    for (int i = 0; i < 8; i += w) begin
      #32 b = (b << w) | 8'(ln == LN_X1 ? {3'h0, pins_in.one} : 4'(pins_in) & 4'((1 << w) - 1));
      oe = oe | dev_oe_in;
      sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
  endtask

  task automatic close_frame();
    #32 cs_n_out = 1'b1;
    #64;
  endtask
endmodule // sfr_host_model

// ---- sfr_read_engine_sva.sv ----
/*
  sfr_read_engine_sva: port-level checks of the read engine.
  Assumes the host clocks the link only while chip select is low.
*/
`timescale 1ns/1ps
module sfr_read_engine_sva
  import sfr_pkg::*;
#(
  parameter int ADDR_W = ARRAY_ADDR_W
) (
  // clocks and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  // link
  input wire logic cs_n_in,
  input wire sfr_lanes_t io_lanes_in,
  input wire sfr_lanes_t io_lanes_out,
  input wire sfr_lanes_t io_lanes_oe_out,
  // device side
  input wire logic busy_in,
  input wire logic quad_enable_bit_in,
  input wire sfr_load_t load_in,
  input wire logic frame_active_out,
  input wire logic continuous_mode_out
);
  logic [7:0] bz_cnt_r;
  logic [7:0] nq_cnt_r;
  sfr_lanes_t rise_val_r;

  // cycles of a frame whose level was already high before the frame opened
  function automatic logic [7:0] run_step(input logic [7:0] c, input logic lvl, input logic idle);
    if (idle) return {7'h00, lvl};
    if (!lvl) return 8'h00;
    return (c == 8'h00 || c == 8'hFF) ? c : c + 8'h01;
  endfunction

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bz_cnt_r <= 8'h00;
      nq_cnt_r <= 8'h00;
    end else begin
      bz_cnt_r <= run_step(bz_cnt_r, busy_in, cs_n_in);
      nq_cnt_r <= run_step(nq_cnt_r, !quad_enable_bit_in, cs_n_in);
    end
  end

  // lane value seen at the rising edge, no reset: only read while driving
  always_ff @(posedge sclk_in) begin
    rise_val_r <= io_lanes_out;
  end

  sequence desel_s;
    cs_n_in [*3];
  endsequence
  sequence sel_s;
    !cs_n_in [*3];
  endsequence

  oe_desel_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
    cs_n_in |-> io_lanes_oe_out == 4'h0) else $error("lane driven while deselected");
  frame_on_a: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_s |-> frame_active_out) else $error("frame flag missing");
  frame_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
    desel_s |-> !frame_active_out) else $error("frame flag stuck");
  lanes_legal_a: assert property (@(posedge clk_in) disable iff (reset_in)
    io_lanes_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad lane set");
  mode_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    desel_s ##1 cs_n_in |-> $stable(continuous_mode_out)) else $error("mode moved while idle");
  busy_refuse_a: assert property (@(posedge clk_in) disable iff (reset_in)
    bz_cnt_r >= 8'h3C |-> io_lanes_oe_out == 4'h0) else $error("read served while busy");
  quad_refuse_a: assert property (@(posedge clk_in) disable iff (reset_in)
    nq_cnt_r >= 8'h3C |-> !io_lanes_oe_out.three && !io_lanes_oe_out.two)
    else $error("quad lanes without enable");
  edge_only_a: assert property (@(negedge sclk_in) disable iff (reset_in || cs_n_in)
    io_lanes_oe_out != 4'h0 |-> io_lanes_out == rise_val_r) else $error("data moved on rise");
endmodule // sfr_read_engine_sva

bind sfr_read_engine sfr_read_engine_sva #(.ADDR_W(ADDR_W)) i_sva (
  .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .io_lanes_in(io_lanes_in), .io_lanes_out(io_lanes_out), .io_lanes_oe_out(io_lanes_oe_out),
  .busy_in(busy_in), .quad_enable_bit_in(quad_enable_bit_in), .load_in(load_in),
  .frame_active_out(frame_active_out), .continuous_mode_out(continuous_mode_out)
);

// ---- serial_flash_read_engine_bench.sv ----
/*
  serial_flash_read_engine_bench: self-checking bench with a byte model of the array.
  Assumes the host model in sfr_host_model and a small 256-byte array.
*/
`timescale 1ns/1ps
module serial_flash_read_engine_bench;
  import sfr_pkg::*;
  localparam int AW = 8;
  localparam int MEM = 1 << AW;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic busy_in = 1'b0;
  logic qe_in = 1'b0;
  logic flt_r = 1'b0;
  sfr_load_t load_in = '0;
  logic sclk;
  logic cs_n;
  logic frame_act;
  logic cont_mode;
  sfr_lanes_t host_v, host_oe, dev_v, dev_oe, pins;
  int fails = 0;
  int comparisons = 0;
  int wrap_dis = 1;
  int wrap_len = 0;
  int cm = 0;
  int mem [MEM];

  always #25 clk_in = ~clk_in;
  // no pulls on the lanes: a released lane toggles so stale data never matches
  always @(posedge clk_in) flt_r <= ~flt_r;
  assign pins = sfr_lanes_t'((dev_oe & dev_v) | (~dev_oe & host_oe & host_v)
    | (~dev_oe & ~host_oe & {flt_r, ~flt_r, flt_r, ~flt_r}));

  sfr_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .lanes_out(host_v),
    .lanes_oe_out(host_oe), .pins_in(pins), .dev_oe_in(dev_oe));
  sfr_read_engine #(.ADDR_W(AW)) i_dut (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .io_lanes_in(pins), .io_lanes_out(dev_v), .io_lanes_oe_out(dev_oe),
    .busy_in(busy_in), .quad_enable_bit_in(qe_in), .load_in(load_in),
    .frame_active_out(frame_act), .continuous_mode_out(cont_mode));

  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  // model address step; wrap only touches four-lane io reads
  function automatic int nxt(input int a, input bit q);
    int s;
    s = 8 << wrap_len;
    if (q && wrap_dis == 0) return (a & ~(s - 1)) | ((a + 1) & (s - 1));
    return (a + 1) & (MEM - 1);
  endfunction

  // one read frame; op 00 means an opcode-less continuous frame
  task automatic rd(input logic [7:0] op, input int a0, input logic [1:0] la,
      input logic [7:0] md, input int dum, input logic [1:0] ld, input int n, input bit ok);
    logic [7:0] b;
    sfr_lanes_t oe;
    sfr_lanes_t msk;
    int a;
    a = a0 & (MEM - 1);
    msk = ok ? sfr_lanes_t'(ld == LN_X1 ? 4'h2 : 4'((1 << (1 << ld)) - 1)) : sfr_lanes_t'(4'h0);
    i_host.open_frame();
    if (op != 8'h00) i_host.send({24'h0, op}, 8, LN_X1);
    i_host.send(32'(a0), 24, la);
    if (la != LN_X1) i_host.send({24'h0, md}, 8, la);
    if (dum > 0) i_host.send(32'h0, dum, la);
    for (int i = 0; i < n; i++) begin
      i_host.recv(ld, b, oe);
      chk(oe === msk, "lane drive");
      if (ok) chk(b === 8'(mem[a]), "read data");
      a = nxt(a, la == LN_X4);
    end
    chk(frame_act === 1'b1, "frame flag high");
    i_host.close_frame();
    if (ok && la != LN_X1) cm = (md[5:4] == MODE_KEEP);
    repeat (4) @(negedge clk_in);
    chk(cont_mode === (cm != 0), "continuous mode");
    chk(i_host.hdr_drive_r === 1'b0, "drive in header");
    chk(frame_act === 1'b0, "frame flag low");
  endtask

  task automatic set_wrap(input logic [7:0] w);
    i_host.open_frame();
    i_host.send({24'h0, OP_SET_WRAP}, 8, LN_X1);
    i_host.send(32'h0, 24, LN_X4);
    i_host.send({24'h0, w}, 8, LN_X4);
    i_host.close_frame();
    wrap_dis = w[4];
    wrap_len = w[6:5];
  endtask

  initial begin
    void'($urandom(32'h69f0));
    repeat (5) @(negedge clk_in);
    reset_in = 1'b0;
    for (int i = 0; i < MEM; i++) begin
      mem[i] = $urandom & 255;
      load_in = '{en: 1'b1, addr: 24'(i), data: 8'(mem[i])};
      @(negedge clk_in);
    end
    load_in.en = 1'b0;
    repeat (4) @(negedge clk_in);
    rd(OP_READ, 24'h3AB0FD, LN_X1, 8'h00, 0, LN_X1, 5, 1);
    rd(OP_FAST, 24'h10, LN_X1, 8'h00, 8, LN_X1, 2, 1);
    rd(OP_DUAL_OUT, 24'h20, LN_X1, 8'h00, 8, LN_X2, 3, 1);
    rd(OP_QUAD_OUT, 24'h30, LN_X1, 8'h00, 8, LN_X4, 8, 0);
    rd(OP_QUAD_IO, 24'h38, LN_X4, 8'h20, 16, LN_X4, 4, 0);
    fin("single lane and refused quad");
    qe_in = 1'b1;
    busy_in = 1'b1;
    rd(OP_READ, 24'h40, LN_X1, 8'h00, 0, LN_X1, 4, 0);
    busy_in = 1'b0;
    rd(OP_QUAD_OUT, 24'h30, LN_X1, 8'h00, 8, LN_X4, 4, 1);
    fin("busy and quad output");
    rd(OP_DUAL_IO, 24'h50, LN_X2, 8'h2F, 0, LN_X2, 2, 1);
    rd(8'h00, 24'h60, LN_X2, 8'h1F, 0, LN_X2, 2, 1);
    rd(OP_READ, 24'h70, LN_X1, 8'h00, 0, LN_X1, 1, 1);
    rd(OP_DUAL_IO, 24'h80, LN_X2, 8'hA0, 0, LN_X2, 1, 1);
    rd(8'h00, 24'hFFFFFF, LN_X2, 8'hFF, 0, LN_X2, 1, 1);
    fin("dual io continuous");
    rd(OP_QUAD_IO, 24'h90, LN_X4, 8'hE5, 16, LN_X4, 2, 1);
    rd(8'h00, 24'hA0, LN_X4, 8'h20, 16, LN_X4, 2, 1);
    rd(8'h00, 24'hFFFFFF, LN_X4, 8'hFF, 16, LN_X4, 1, 1);
    fin("quad io continuous");
    for (int l = 0; l < 4; l++) begin
      set_wrap({1'b1, 2'(l), 1'b0, 4'hA});
      rd(OP_QUAD_IO, 24'hC5 + l, LN_X4, 8'h00, 16, LN_X4, (8 << l) + 3, 1);
    end
    // mid-run reset: continuous mode and wrap setting fall back to defaults
    rd(OP_DUAL_IO, 24'h80, LN_X2, 8'hA0, 0, LN_X2, 1, 1);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    cm = 0;
    wrap_dis = 1;
    wrap_len = 0;
    rd(OP_QUAD_IO, 24'hFA, LN_X4, 8'h00, 16, LN_X4, 12, 1);
    set_wrap(8'h10);
    rd(OP_QUAD_IO, 24'hC6, LN_X4, 8'h00, 16, LN_X4, 12, 1);
    fin("burst wrap");
    wrap_up();
  end

  // watchdog well beyond the expected run of under a millisecond
  initial begin
    #3000000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // serial_flash_read_engine_bench
